// File: verilog/ces_top.sv
`timescale 1ns/10ps
// Summary of operation
// - Temperature events interrupt when group and direction enabled.
// - Input voltage events interrupt when group and direction enabled.
// - End-of-charge entry/exit interrupts, gated by group enable.
// - Timer flag shows either safety timeout occurred.
// - Temperature flag shows battery inside valid range.
// - Input flag shows valid supply at charger input.
// - End-of-charge flag shows charger in end-of-charge.
// - Total timeout interrupts with control and timer enable.
// - Temperature entering range interrupts when both bits set.
// - Input becoming valid interrupts when both bits set.
// - Entering end-of-charge interrupts when both bits set.
// - Temperature leaving range interrupts when both bits set.
// - Input becoming invalid interrupts when both bits set.
// - Mains source bit shows charging from adapter.
// - Bus source bit shows charging from USB.
// - Two-bit field reports present charging state.
// - Level bit mirrors the charge-level pin.
// - Software turns each switch on or off by bit.
// - Marked bits valid only while input supply valid.
// - Timer enable bit gates timer events, reads status.
module ces_top
(
    // Clock and reset.
    input  wire logic                        CLK,
    input  wire logic                        NRST,
    // Register access from the serial interface, same clock.
    input  wire ces_pkg::ces_reg_req_t       REG_REQ,
    output logic      [ces_pkg::DATA_W-1:0]  REG_RDATA,
    output logic                             REG_RVALID,
    // Charger levels, asynchronous to the clock.
    input  wire ces_pkg::ces_status_t        STATUS_IN,
    // Interrupt request, active high.
    output logic                             CHG_IRQ,
    // Power switch enables.
    output logic                             OTG_SWITCH_A,
    output logic                             OTG_SWITCH_B,
    output logic                             OTG_SWITCH_C
);
    import ces_pkg::*;

    // ======================================================================
    // Declarations.
    // ======================================================================
    localparam int unsigned EDGE_W = 5;
    localparam int unsigned E_PRE  = 4;
    localparam int unsigned E_TOT  = 3;
    localparam int unsigned E_TEMP = 2;
    localparam int unsigned E_IN   = 1;
    localparam int unsigned E_EOC  = 0;

    logic [STATUS_W-1:0] status_vec;
    ces_status_t         status_s;
    logic [EDGE_W-1:0]   edge_level;
    logic [EDGE_W-1:0]   edge_rise;
    logic [EDGE_W-1:0]   edge_fall;

    ces_groups_t         enable_r;
    ces_groups_t         enable_nxt;
    ces_groups_t         pending_r;
    ces_groups_t         pending_nxt;
    ces_groups_t         event_set;
    logic [DATA_W-1:0]   controls_r;
    logic [2:0]          switches_r;
    logic                input_ok;
    logic                timer_flag;
    logic                read_status;
    logic [DATA_W-1:0]   rdata_nxt;

    // Decodes a write strobe to one register offset.
    function automatic logic wr_hit(input ces_reg_req_t req, input logic [ADDR_W-1:0] ofs);
        return req.wr && (req.addr == ofs);
    endfunction

    // Decodes a read strobe to one register offset.
    function automatic logic rd_hit(input ces_reg_req_t req, input logic [ADDR_W-1:0] ofs);
        return req.rd && (req.addr == ofs);
    endfunction

    // ======================================================================
    // Synchronisation of charger levels and edge detection.
    // ======================================================================

    // Every charger level passes two flip-flops before any logic reads it.
    ces_sync
    #(
        .WIDTH (STATUS_W)
    )
    u_sync
    (
        .clk  (CLK),
        .nrst (NRST),
        .d    (STATUS_IN),
        .q    (status_vec)
    );

    assign status_s = ces_status_t'(status_vec);

    // Levels whose transitions are charger events.
    assign edge_level = {status_s.precharge_timeout,
                         status_s.total_timeout,
                         status_s.temp_valid,
                         status_s.input_valid,
                         status_s.end_of_charge};

    ces_edge
    #(
        .WIDTH (EDGE_W)
    )
    u_edge
    (
        .clk   (CLK),
        .nrst  (NRST),
        .level (edge_level),
        .rise  (edge_rise),
        .fall  (edge_fall)
    );

    // ======================================================================
    // Validity of the marked bits.
    // ======================================================================

    // Charger status and its events mean something only with a valid supply.
    assign input_ok   = status_s.input_valid;
    assign timer_flag = status_s.precharge_timeout | status_s.total_timeout;

    // ======================================================================
    // Event qualification.
    // ======================================================================

    // Safety timer expiries, each gated by its control bit and the group enable.
    assign event_set.timer = enable_r.timer && input_ok &&
        ((edge_rise[E_TOT] && controls_r[BIT_TOTAL_TIMEOUT]) ||
         (edge_rise[E_PRE] && controls_r[BIT_PRE_TIMEOUT]));

    // Temperature entering or leaving the valid range.
    assign event_set.temp = enable_r.temp && input_ok &&
        ((edge_rise[E_TEMP] && controls_r[BIT_TEMP_INTO]) ||
         (edge_fall[E_TEMP] && controls_r[BIT_TEMP_OUT]));

    // Input supply becoming valid or invalid; the loss itself is not masked.
    assign event_set.input_v = enable_r.input_v &&
        ((edge_rise[E_IN] && controls_r[BIT_INPUT_VALID]) ||
         (edge_fall[E_IN] && controls_r[BIT_INPUT_INVALID]));

    // Charger state machine entering or leaving end-of-charge.
    assign event_set.charge = enable_r.charge && input_ok &&
        ((edge_rise[E_EOC] && controls_r[BIT_EOC_ENTRY]) ||
         (edge_fall[E_EOC] && controls_r[BIT_EOC_EXIT]));

    // ======================================================================
    // Group enables.
    // ======================================================================

    // The upper nibble of the status register is written as the group enables.
    always_comb
    begin
        enable_nxt = enable_r;
        if (wr_hit(REG_REQ, OFS_EVENT_STATUS))
        begin
            enable_nxt.timer   = REG_REQ.wdata[BIT_TIMER_EN];
            enable_nxt.temp    = REG_REQ.wdata[BIT_TEMP_EN];
            enable_nxt.input_v = REG_REQ.wdata[BIT_INPUT_EN];
            enable_nxt.charge  = REG_REQ.wdata[BIT_CHARGE_EN];
        end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            enable_r <= ces_groups_t'(RST_ENABLES);
        end
        else
        begin
            enable_r <= enable_nxt;
        end
    end

    // ======================================================================
    // Event direction controls.
    // ======================================================================

    // All eight control bits are plain read/write storage.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            controls_r <= RST_CONTROLS;
        end
        else if (wr_hit(REG_REQ, OFS_EVENT_CONTROLS))
        begin
            controls_r <= REG_REQ.wdata;
        end
    end

    // ======================================================================
    // Pending events and interrupt.
    // ======================================================================

    // Reading the status register services every pending event.
    assign read_status = rd_hit(REG_REQ, OFS_EVENT_STATUS);

    // A new event wins over the clear of the same cycle; disabling a group
    // drops its pending event so the request cannot stick.
    always_comb
    begin
        pending_nxt = ces_groups_t'(
            (event_set | (pending_r & ~{4{read_status}})) & enable_nxt);
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pending_r <= ces_groups_t'(RST_PENDING);
        end
        else
        begin
            pending_r <= pending_nxt;
        end
    end

    // The request is the OR of every pending enabled event.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            CHG_IRQ <= 1'b0;
        end
        else
        begin
            CHG_IRQ <= |pending_nxt;
        end
    end

    // ======================================================================
    // Power switches.
    // ======================================================================

    // Each switch follows its own enable bit; the other bits are not kept.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            switches_r <= RST_SWITCHES;
        end
        else if (wr_hit(REG_REQ, OFS_OTG_SWITCH))
        begin
            switches_r <= {REG_REQ.wdata[BIT_SWITCH_A],
                           REG_REQ.wdata[BIT_SWITCH_B],
                           REG_REQ.wdata[BIT_SWITCH_C]};
        end
    end

    // Switch drives come straight from their flip-flops.
    assign OTG_SWITCH_A = switches_r[2];
    assign OTG_SWITCH_B = switches_r[1];
    assign OTG_SWITCH_C = switches_r[0];

    // ======================================================================
    // Read multiplexer.
    // ======================================================================

    // Reserved and unmapped bits read as zero.
    always_comb
    begin
        rdata_nxt = RST_BYTE;
        case (REG_REQ.addr)
            OFS_EVENT_STATUS:
            begin
                rdata_nxt[BIT_TIMER_EN]   = pending_r.timer & input_ok;
                rdata_nxt[BIT_TEMP_EN]    = pending_r.temp & input_ok;
                rdata_nxt[BIT_INPUT_EN]   = pending_r.input_v;
                rdata_nxt[BIT_CHARGE_EN]  = pending_r.charge & input_ok;
                rdata_nxt[BIT_TIMER_FLAG] = timer_flag & input_ok;
                rdata_nxt[BIT_TEMP_FLAG]  = status_s.temp_valid;
                rdata_nxt[BIT_INPUT_FLAG] = status_s.input_valid;
                rdata_nxt[BIT_EOC_FLAG]   = status_s.end_of_charge & input_ok;
            end
            OFS_EVENT_CONTROLS:
            begin
                rdata_nxt = controls_r;
            end
            OFS_SOURCE_STATE:
            begin
                rdata_nxt[BIT_MAINS_SOURCE] = status_s.mains_source;
                rdata_nxt[BIT_BUS_SOURCE]   = status_s.bus_source;
                rdata_nxt[BIT_STATE_HI]     = status_s.charging_state[1];
                rdata_nxt[BIT_STATE_LO]     = status_s.charging_state[0];
                rdata_nxt[BIT_LEVEL_PIN]    = status_s.charge_level_pin;
            end
            OFS_OTG_SWITCH:
            begin
                rdata_nxt[BIT_SWITCH_A] = switches_r[2];
                rdata_nxt[BIT_SWITCH_B] = switches_r[1];
                rdata_nxt[BIT_SWITCH_C] = switches_r[0];
            end
            default:
            begin
                rdata_nxt = RST_BYTE;
            end
        endcase
    end

    // Read data is registered and valid for one cycle after the strobe.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            REG_RDATA  <= RST_BYTE;
            REG_RVALID <= 1'b0;
        end
        else
        begin
            REG_RVALID <= REG_REQ.rd;
            if (REG_REQ.rd)
            begin
                REG_RDATA <= rdata_nxt;
            end
        end
    end
endmodule

// File: verilog/ces_pkg.sv
// ==========================================================================
// Shared constants and carriers for the charger event and status registers.
// ==========================================================================
package ces_pkg;

    // ======================================================================
    // Register port geometry.
    // ======================================================================
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // ======================================================================
    // Register offsets.
    // ======================================================================
    localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS   = 8'hA8;
    localparam logic [ADDR_W-1:0] OFS_EVENT_CONTROLS = 8'hA9;
    localparam logic [ADDR_W-1:0] OFS_SOURCE_STATE   = 8'hAA;
    localparam logic [ADDR_W-1:0] OFS_OTG_SWITCH     = 8'hB0;

    // ======================================================================
    // Field positions of the event status register.
    // ======================================================================
    localparam int unsigned BIT_TIMER_EN   = 7;
    localparam int unsigned BIT_TEMP_EN    = 6;
    localparam int unsigned BIT_INPUT_EN   = 5;
    localparam int unsigned BIT_CHARGE_EN  = 4;
    localparam int unsigned BIT_TIMER_FLAG = 3;
    localparam int unsigned BIT_TEMP_FLAG  = 2;
    localparam int unsigned BIT_INPUT_FLAG = 1;
    localparam int unsigned BIT_EOC_FLAG   = 0;

    // ======================================================================
    // Field positions of the event control register.
    // ======================================================================
    localparam int unsigned BIT_TOTAL_TIMEOUT = 7;
    localparam int unsigned BIT_TEMP_INTO     = 6;
    localparam int unsigned BIT_INPUT_VALID   = 5;
    localparam int unsigned BIT_EOC_ENTRY     = 4;
    localparam int unsigned BIT_PRE_TIMEOUT   = 3;
    localparam int unsigned BIT_TEMP_OUT      = 2;
    localparam int unsigned BIT_INPUT_INVALID = 1;
    localparam int unsigned BIT_EOC_EXIT      = 0;

    // ======================================================================
    // Field positions of the source state and switch control registers.
    // ======================================================================
    localparam int unsigned BIT_MAINS_SOURCE = 7;
    localparam int unsigned BIT_BUS_SOURCE   = 6;
    localparam int unsigned BIT_STATE_HI     = 5;
    localparam int unsigned BIT_STATE_LO     = 4;
    localparam int unsigned BIT_LEVEL_PIN    = 0;
    localparam int unsigned BIT_SWITCH_A     = 7;
    localparam int unsigned BIT_SWITCH_B     = 6;
    localparam int unsigned BIT_SWITCH_C     = 5;

    // ======================================================================
    // Reset values.
    // ======================================================================
    localparam logic [3:0]        RST_ENABLES  = 4'h0;
    localparam logic [3:0]        RST_PENDING  = 4'h0;
    localparam logic [DATA_W-1:0] RST_CONTROLS = 8'h00;
    localparam logic [DATA_W-1:0] RST_BYTE     = 8'h00;
    localparam logic [2:0]        RST_SWITCHES = 3'h0;

    // ======================================================================
    // Carriers.
    // ======================================================================
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ces_reg_req_t;

    typedef struct packed {
        logic       precharge_timeout;
        logic       total_timeout;
        logic       temp_valid;
        logic       input_valid;
        logic       end_of_charge;
        logic       mains_source;
        logic       bus_source;
        logic [1:0] charging_state;
        logic       charge_level_pin;
    } ces_status_t;

    localparam int unsigned STATUS_W = $bits(ces_status_t);

    // Event groups, one pending flag each.
    typedef struct packed {
        logic timer;
        logic temp;
        logic input_v;
        logic charge;
    } ces_groups_t;

endpackage

// File: verilog/ces_sync.sv
`timescale 1ns/10ps
// ==========================================================================
// Two-stage synchroniser for a vector of slow levels.
// ==========================================================================
module ces_sync
#(
    parameter int unsigned WIDTH = 1
)
(
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             nrst,
    // Levels from outside the clock domain and their synchronised copy.
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_r <= '0;
            q      <= '0;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// File: verilog/ces_edge.sv
`timescale 1ns/10ps
// ==========================================================================
// Rise and fall detector for a vector of synchronised levels.
// ==========================================================================
module ces_edge
#(
    parameter int unsigned WIDTH = 1
)
(
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             nrst,
    // Level in, one-cycle edge pulses out.
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] prev_r;
    logic [2:0]       armed_r;

    // Edges wait until the reset value has left the synchroniser.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            prev_r  <= '0;
            armed_r <= '0;
        end
        else
        begin
            prev_r  <= level;
            armed_r <= {armed_r[1:0], 1'b1};
        end
    end

    // Edges compare the present level with the one before.
    assign rise = armed_r[2] ? (level & ~prev_r) : '0;
    assign fall = armed_r[2] ? (~level & prev_r) : '0;
endmodule

// File: dv/ces_top_monitor.sv
`timescale 1ns/10ps
// ==========
// Port checker for the charger event and status registers.
module ces_top_monitor
(
    // Clock and reset.
    input wire logic                       CLK,
    input wire logic                       NRST,
    // Register port.
    input wire ces_pkg::ces_reg_req_t      REG_REQ,
    input wire logic [ces_pkg::DATA_W-1:0] REG_RDATA,
    input wire logic                       REG_RVALID,
    // Charger levels and outputs.
    input wire ces_pkg::ces_status_t       STATUS_IN,
    input wire logic                       CHG_IRQ,
    input wire logic                       OTG_SWITCH_A,
    input wire logic                       OTG_SWITCH_B,
    input wire logic                       OTG_SWITCH_C
);
    import ces_pkg::*;
    ces_status_t prev_r;
    logic [2:0]  stc_r;
    logic        rd_a8;
    logic        rd_aa;
    logic        wr_a8;
    logic        wr_b0;
    logic        rd_bad;
    logic [7:0]  aa_exp;
    logic [3:0]  lo_exp;
    // Decoded accesses and the bytes a settled read returns.
    assign rd_a8  = REG_REQ.rd && REG_REQ.addr == OFS_EVENT_STATUS;
    assign rd_aa  = REG_REQ.rd && REG_REQ.addr == OFS_SOURCE_STATE;
    assign wr_a8  = REG_REQ.wr && REG_REQ.addr == OFS_EVENT_STATUS;
    assign wr_b0  = REG_REQ.wr && REG_REQ.addr == OFS_OTG_SWITCH;
    assign rd_bad = REG_REQ.rd && !(REG_REQ.addr inside {8'hA8, 8'hA9, 8'hAA, 8'hB0});
    assign aa_exp = {STATUS_IN.mains_source, STATUS_IN.bus_source,
                     STATUS_IN.charging_state, 3'h0, STATUS_IN.charge_level_pin};
    assign lo_exp = {(STATUS_IN.precharge_timeout | STATUS_IN.total_timeout)
                     & STATUS_IN.input_valid, STATUS_IN.temp_valid,
                     STATUS_IN.input_valid, STATUS_IN.end_of_charge & STATUS_IN.input_valid};
    // Cycles since the charger levels last changed, up to 7.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            prev_r <= '0;
            stc_r  <= 3'h0;
        end
        else
        begin
            prev_r <= STATUS_IN;
            if (STATUS_IN != prev_r)
                stc_r <= 3'h0;
            else if (stc_r != 3'h7)
                stc_r <= stc_r + 3'h1;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    // ==========
    // Assertions.
    rd_answer_a: assert property (REG_REQ.rd |=> REG_RVALID)
        else $error("read not answered next cycle");
    rvalid_cause_a: assert property (REG_RVALID |-> $past(REG_REQ.rd))
        else $error("read valid without a read");
    switch_write_a: assert property (wr_b0 |=>
        {OTG_SWITCH_A, OTG_SWITCH_B, OTG_SWITCH_C} == $past(REG_REQ.wdata[7:5]))
        else $error("switch outputs differ from written bits");
    switch_hold_a: assert property (!wr_b0 |=>
        $stable({OTG_SWITCH_A, OTG_SWITCH_B, OTG_SWITCH_C}))
        else $error("switch outputs changed without a write");
    source_read_a: assert property (rd_aa && stc_r == 3'h7 |=>
        REG_RDATA == $past(aa_exp))
        else $error("source state byte wrong");
    status_read_a: assert property (rd_a8 && stc_r == 3'h7 |=>
        REG_RDATA[3:0] == $past(lo_exp))
        else $error("event status flags wrong");
    unmapped_read_a: assert property (rd_bad |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    irq_clear_a: assert property ($fell(CHG_IRQ) |->
        $past(rd_a8 || wr_a8) || $past(wr_a8, 2))
        else $error("interrupt dropped without service");
    irq_cause_a: assert property ($rose(CHG_IRQ) |-> stc_r <= 3'h5)
        else $error("interrupt raised without a level change");
    pending_read_a: assert property (CHG_IRQ && rd_a8 && lo_exp[1] && stc_r[2] |=>
        REG_RDATA[7:4] != 4'h0)
        else $error("interrupt high but no pending group read");
    // Main scenarios.
    irq_seen_c: cover property ($rose(CHG_IRQ));
    irq_serviced_c: cover property (CHG_IRQ && rd_a8);
    switch_set_c: cover property (wr_b0 && REG_REQ.wdata[7]);
endmodule

// File: dv/ces_host.sv
`timescale 1ns/10ps
// ==========
// Host side of the register port: single-byte writes and reads.
module ces_host
(
    // Clock.
    input wire logic                       CLK,
    // Register port.
    output ces_pkg::ces_reg_req_t          REG_REQ,
    input wire logic [ces_pkg::DATA_W-1:0] REG_RDATA,
    input wire logic                       REG_RVALID
);
    import ces_pkg::*;
    // Idle port at time zero.
    initial REG_REQ = '0;
    // One-cycle write strobe; data is inverted once released.
    task do_wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge CLK);
        #1 REG_REQ = '{addr: a, wdata: dat, wr: 1'b1, rd: 1'b0};
        @(posedge CLK);
        #1 REG_REQ.wr = 1'b0;
        REG_REQ.wdata = ~dat;
    endtask
    // One-cycle read strobe, then a bounded wait for the answer.
    task do_rd(input logic [7:0] a, output logic [7:0] dat);
        int n;
        @(posedge CLK);
        #1 REG_REQ = '{addr: a, wdata: REG_REQ.wdata, wr: 1'b0, rd: 1'b1};
        @(posedge CLK);
        #1 REG_REQ.rd = 1'b0;
        n = 0;
        while (REG_RVALID !== 1'b1 && n < 8)
        begin
            @(posedge CLK);
            #1 n++;
        end
        dat = (REG_RVALID === 1'b1) ? REG_RDATA : 8'hXX;
    endtask
endmodule

// File: dv/test_ces_top.sv
`timescale 1ns/10ps
// ==========
// Compares a value and counts the outcome.
`define CHK(nm, ex, got) \
    begin \
        n_tests++; \
        if ((got) !== (ex)) \
        begin \
            err_total++; \
            $display("wrong value %s exp %h got %h", nm, ex, got); \
        end \
    end
module test_ces_top;
    import ces_pkg::*;
    logic                CLK;
    logic                NRST;
    logic [STATUS_W-1:0] st;
    ces_reg_req_t        req;
    logic [DATA_W-1:0]   rdata;
    logic [DATA_W-1:0]   d;
    logic                rvalid;
    logic                irq;
    logic                sw_a;
    logic                sw_b;
    logic                sw_c;
    int                  err_total;
    int                  n_tests;
    int                  cyc;
    int                  cbs [8] = '{7, 3, 6, 2, 5, 1, 4, 0};
    int                  sbs [8] = '{8, 9, 7, 7, 6, 6, 5, 5};
    logic [0:7]          rs = 8'hEA;
    logic [9:0]          pats [4] = '{10'h3FF, 10'h3BF, 10'h155, 10'h2AA};
    // Design and host model.
    ces_top u_ces_top (.CLK(CLK), .NRST(NRST), .REG_REQ(req), .REG_RDATA(rdata),
        .REG_RVALID(rvalid), .STATUS_IN(ces_status_t'(st)), .CHG_IRQ(irq),
        .OTG_SWITCH_A(sw_a), .OTG_SWITCH_B(sw_b), .OTG_SWITCH_C(sw_c));
    ces_host u_ces_host (.CLK(CLK), .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid));
    // 200 MHz clock.
    initial
    begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    // ==========
    // Helpers.
    function automatic logic [7:0] lo8(input logic [9:0] s);
        return {4'h0, (s[9] | s[8]) & s[6], s[7], s[6], s[5] & s[6]};
    endfunction
    task wait_n(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] dat);
        u_ces_host.do_wr(a, dat);
    endtask
    task rd_chk(input logic [7:0] a, input logic [7:0] ex, input string nm);
        u_ces_host.do_rd(a, d);
        `CHK(nm, ex, d)
    endtask
    task stop_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            stop_test();
        end
    end
    // ==========
    // Main sequence.
    initial
    begin
        NRST = 1'b0;
        st = '0;
        wait_n(6);
        NRST = 1'b1;
        `CHK("irq rst", 1'b0, irq)
        `CHK("sw rst", 3'h0, {sw_a, sw_b, sw_c})
        rd_chk(OFS_EVENT_STATUS, 8'h00, "a8 rst");
        rd_chk(OFS_EVENT_CONTROLS, 8'h00, "a9 rst");
        rd_chk(OFS_SOURCE_STATE, 8'h00, "aa rst");
        rd_chk(OFS_OTG_SWITCH, 8'h00, "b0 rst");
        wr(OFS_EVENT_CONTROLS, 8'hA5);
        rd_chk(OFS_EVENT_CONTROLS, 8'hA5, "a9 rw");
        wr(OFS_EVENT_CONTROLS, 8'h5A);
        rd_chk(OFS_EVENT_CONTROLS, 8'h5A, "a9 rw");
        wr(OFS_OTG_SWITCH, 8'hFF);
        rd_chk(OFS_OTG_SWITCH, 8'hE0, "b0 rw");
        `CHK("sw on", 3'h7, {sw_a, sw_b, sw_c})
        wr(OFS_OTG_SWITCH, 8'h40);
        `CHK("sw b", 3'h2, {sw_a, sw_b, sw_c})
        wr(OFS_SOURCE_STATE, 8'hFF);
        rd_chk(OFS_SOURCE_STATE, 8'h00, "aa ro");
        wr(8'h55, 8'hFF);
        rd_chk(8'h55, 8'h00, "unmapped");
        rd_chk(OFS_EVENT_CONTROLS, 8'h5A, "a9 kept");
        $display("test registers done");
        foreach (pats[i])
        begin
            st = pats[i];
            wait_n(10);
            rd_chk(OFS_SOURCE_STATE, {st[4:1], 3'h0, st[0]}, "aa");
            rd_chk(OFS_EVENT_STATUS, lo8(st), "a8 flags");
        end
        $display("test status done");
        for (int i = 0; i < 8; i++)
        begin
            st = 10'h040;
            st[sbs[i]] = !rs[i];
            wait_n(8);
            wr(OFS_EVENT_STATUS, 8'h10 << (cbs[i] % 4));
            wr(OFS_EVENT_CONTROLS, 8'h01 << (cbs[i] ^ 4));
            u_ces_host.do_rd(OFS_EVENT_STATUS, d);
            st[sbs[i]] = rs[i];
            wait_n(8);
            `CHK("irq other dir", 1'b0, irq)
            wr(OFS_EVENT_CONTROLS, 8'h01 << cbs[i]);
            st[sbs[i]] = !rs[i];
            wait_n(8);
            `CHK("irq reverse", 1'b0, irq)
            st[sbs[i]] = rs[i];
            wait_n(8);
            `CHK("irq on", 1'b1, irq)
            rd_chk(OFS_EVENT_STATUS, (8'h10 << (cbs[i] % 4)) | lo8(st), "pend");
            `CHK("irq clr", 1'b0, irq)
        end
        $display("test events done");
        st = 10'h000;
        wait_n(8);
        wr(OFS_EVENT_STATUS, 8'h80);
        wr(OFS_EVENT_CONTROLS, 8'h88);
        st = 10'h300;
        wait_n(8);
        `CHK("irq no input", 1'b0, irq)
        NRST = 1'b0;
        wait_n(2);
        NRST = 1'b1;
        `CHK("sw rst2", 3'h0, {sw_a, sw_b, sw_c})
        rd_chk(OFS_EVENT_CONTROLS, 8'h00, "a9 rst2");
        $display("test masking and reset done");
        stop_test();
    end
endmodule
bind ces_top ces_top_monitor u_ces_top_monitor (.CLK(CLK), .NRST(NRST), .REG_REQ(REG_REQ),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .STATUS_IN(STATUS_IN), .CHG_IRQ(CHG_IRQ),
    .OTG_SWITCH_A(OTG_SWITCH_A), .OTG_SWITCH_B(OTG_SWITCH_B), .OTG_SWITCH_C(OTG_SWITCH_C));
